// ### design/four_port_parallel_io_mux.sv
// Four 8-bit ports with mode-dependent sharing of pins with the multiplexed bus
// Behaviour
// - Four 8-bit ports; every line of second, third, fourth port is bidirectional.
// - Second, third port and fourth bits 6,7 are GPIO only in single-chip/bootstrap.
// - First-port read returns pin for inputs, driver level for outputs.
// - First-port write goes to a latch that drives only output pins.
// - Compare-owned first-port pins ignore software writes.
// - After reset first-port bits 7,3..0 are inputs; bits 6..4 drive low.
// - Bits 7 and 3 direction come from pulse accumulator control when compare off.
// - Expanded mode: second port outputs address bits 15..8.
// - Other port reads return pin for inputs, driver level for outputs.
// - Second/third port latch reaches pins only as GPIO outputs in single-chip/boot.
// - Second port: GPIO set by its direction register in single-chip/boot, high address in expanded/test.
// - Third port: GPIO set by its direction register in single-chip/boot, address/data in expanded/test.
// - Third port gives low address, then data steered by read/write.
// - Open-drain bit disables high-side drive on all third-port lines.
// - Open-drain: bit zero drives low, bit one floats.
// - Open-drain is allowed only in single-chip mode.
// - Fourth-port lines 0,1 serve async serial; lines 2..5 serve SPI.
// - Expanded/test: fourth-port bits 6,7 give address strobe and read/write.
// - Fourth-port latch drives only general-purpose output lines.
// - Read/write is high for reads, low for writes.
`timescale 1ns/1ns
module four_port_parallel_io_mux
  import parallel_io_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Mode straps
  input  wire logic [1:0]  modePins,
  // Register port
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [3:0]  regSel,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  rdData,
  output logic             rdValid,
  // Timer compare sharing on first port, bits 3..7
  input  wire logic [4:0]  compareEn,
  input  wire logic [4:0]  compareLevel,
  // Serial and SPI sharing on fourth port
  input  wire logic        sciEn,
  input  wire logic        sciTxd,
  input  wire logic        spiEn,
  input  wire logic [3:0]  spiOut,
  input  wire logic [3:0]  spiDrive,
  // External bus request
  input  wire logic        busReq,
  input  wire logic        busWriteReq,
  input  wire logic [15:0] busAddrReq,
  input  wire logic [7:0]  busWdataReq,
  output logic [7:0]       busRdData,
  output logic             busDone,
  output logic             busBusy,
  output logic             expandedMode,
  // First port pins
  input  wire logic [7:0]  timerPinIn,
  output logic [7:0]       timerPinOut,
  output logic [7:0]       timerPinOeN,
  // Second port pins
  input  wire logic [7:0]  highPinIn,
  output logic [7:0]       highPinOut,
  output logic [7:0]       highPinOeN,
  // Third port pins
  input  wire logic [7:0]  muxedPinIn,
  output logic [7:0]       muxedPinOut,
  output logic [7:0]       muxedPinOeN,
  // Fourth port pins
  input  wire logic [7:0]  serialPinIn,
  output logic [7:0]       serialPinOut,
  output logic [7:0]       serialPinOeN
);

  ioState_t s;
  ioState_t next_s;

  localparam ioState_t RESET_STATE = '{
    regs: '{
      timerPortData:     RESET_DATA,
      pulseAccumCtrlReg: RESET_PULSE_ACCUM_CTRL_REG,
      highPortDataReg:   RESET_DATA,
      highPortDirReg:    RESET_DIR,
      muxedPortDataReg:  RESET_DATA,
      muxedPortDirReg:   RESET_DIR,
      serialPortDataReg: RESET_DATA,
      serialPortDirReg:  RESET_DIR,
      parallelIoCtrlReg: RESET_PARALLEL_IO_CTRL_REG
    },
    busState: BUS_IDLE,
    timerPins: '{out: 8'h00, oeN: 8'h8f},
    highPins:  '{out: 8'h00, oeN: 8'hff},
    muxedPins: '{out: 8'h00, oeN: 8'hff},
    serialPins: '{out: 8'h00, oeN: 8'hff},
    default: '0
  };

  // Inputs read back pin, outputs read back the driver input
  function automatic logic [7:0] readMix(input logic [7:0] pins, input portPins_t drv);
    readMix = (~drv.oeN & drv.out) | (drv.oeN & pins);
  endfunction : readMix

  logic singleChip;
  logic gpioMode;
  logic openDrain;
  logic [7:0] timerDrive;
  logic [7:0] timerValue;

  always_comb begin
    next_s = s;
    singleChip = s.modeValid && (s.mode == MODE_SINGLE);
    gpioMode   = !s.expanded;
    openDrain  = singleChip && s.regs.parallelIoCtrlReg[PARALLEL_IO_CTRL_REG_OPEN_DRAIN];
    timerDrive = 8'h00;
    timerValue = s.regs.timerPortData;

    // Two-flop synchronisers for every pin and strap
    next_s.modeMeta   = modePins;
    next_s.modeSync   = s.modeMeta;
    next_s.timerMeta  = timerPinIn;
    next_s.timerSync  = s.timerMeta;
    next_s.highMeta   = highPinIn;
    next_s.highSync   = s.highMeta;
    next_s.muxedMeta  = muxedPinIn;
    next_s.muxedSync  = s.muxedMeta;
    next_s.serialMeta = serialPinIn;
    next_s.serialSync = s.serialMeta;

    // Strap caught once the synchroniser holds post-reset samples
    if (!s.modeValid) begin
      if (s.modeCnt == STRAP_SETTLE) begin
        next_s.mode      = s.modeSync;
        next_s.modeValid = 1'b1;
        next_s.expanded  = s.modeSync[0];
      end else begin
        next_s.modeCnt = s.modeCnt + 2'h1;
      end
    end

    // Register writes
    if (regWr) begin
      unique case (regSel)
        REG_TIMER_PORT_DATA:  next_s.regs.timerPortData     = regWdata;
        REG_PULSE_ACCUM_CTRL: next_s.regs.pulseAccumCtrlReg = regWdata;
        REG_HIGH_PORT_DATA:   next_s.regs.highPortDataReg   = regWdata;
        REG_HIGH_PORT_DIR:    next_s.regs.highPortDirReg    = regWdata;
        REG_MUXED_PORT_DATA:  next_s.regs.muxedPortDataReg  = regWdata;
        REG_MUXED_PORT_DIR:   next_s.regs.muxedPortDirReg   = regWdata;
        REG_SERIAL_PORT_DATA: next_s.regs.serialPortDataReg = regWdata;
        REG_SERIAL_PORT_DIR:  next_s.regs.serialPortDirReg  = regWdata;
        REG_PARALLEL_IO_CTRL: next_s.regs.parallelIoCtrlReg = regWdata;
        default: ;
      endcase
    end

    // Register reads, answered one cycle later
    next_s.rdValid = regRd;
    if (regRd) begin
      unique case (regSel)
        REG_TIMER_PORT_DATA:  next_s.rdData = readMix(s.timerSync, s.timerPins);
        REG_PULSE_ACCUM_CTRL: next_s.rdData = s.regs.pulseAccumCtrlReg;
        REG_HIGH_PORT_DATA:   next_s.rdData = readMix(s.highSync, s.highPins);
        REG_HIGH_PORT_DIR:    next_s.rdData = s.regs.highPortDirReg;
        REG_MUXED_PORT_DATA:  next_s.rdData = readMix(s.muxedSync, s.muxedPins);
        REG_MUXED_PORT_DIR:   next_s.rdData = s.regs.muxedPortDirReg;
        REG_SERIAL_PORT_DATA: next_s.rdData = readMix(s.serialSync, s.serialPins);
        REG_SERIAL_PORT_DIR:  next_s.rdData = s.regs.serialPortDirReg;
        REG_PARALLEL_IO_CTRL: next_s.rdData = s.regs.parallelIoCtrlReg;
        default:              next_s.rdData = 8'h00;
      endcase
    end

    // External bus cycle: one address cycle, then the data phase
    next_s.busDone = 1'b0;
    unique case (s.busState)
      BUS_IDLE: begin
        if (busReq && s.expanded) begin
          next_s.busAddr  = busAddrReq;
          next_s.busWdata = busWdataReq;
          next_s.busWrite = busWriteReq;
          next_s.busState = BUS_ADDR;
          next_s.busBusy  = 1'b1;
        end
      end
      BUS_ADDR: begin
        next_s.busState = BUS_DATA;
        next_s.busCnt   = 3'h0;
      end
      BUS_DATA: begin
        next_s.busCnt = s.busCnt + 3'h1;
        // Long data phase gives the pin synchroniser time to settle
        if (s.busCnt == BUS_DATA_CYCLES - 3'h1) begin
          if (!s.busWrite) begin
            next_s.busRdData = s.muxedSync;
          end
          next_s.busDone  = 1'b1;
          next_s.busBusy  = 1'b0;
          next_s.busState = BUS_IDLE;
        end
      end
    endcase

    // First port: 2..0 input only, 6..4 output only, 7 and 3 switchable
    timerDrive[6:4] = 3'h7;
    timerDrive[3] = compareEn[0] | s.regs.pulseAccumCtrlReg[PULSE_ACCUM_CTRL_REG_DIR_BIT3];
    timerDrive[7] = compareEn[4] | s.regs.pulseAccumCtrlReg[PULSE_ACCUM_CTRL_REG_DIR_BIT7];
    for (int i = 0; i < 5; i++) begin
      if (compareEn[i]) begin
        timerValue[i + 3] = compareLevel[i];
      end
    end
    next_s.timerPins.out = timerValue;
    next_s.timerPins.oeN = ~timerDrive;

    // Second port
    if (gpioMode) begin
      next_s.highPins.out = s.regs.highPortDataReg;
      next_s.highPins.oeN = ~s.regs.highPortDirReg;
    end else begin
      next_s.highPins.out = s.busAddr[15:8];
      next_s.highPins.oeN = 8'h00;
    end

    // Third port
    if (gpioMode) begin
      next_s.muxedPins.out = s.regs.muxedPortDataReg;
      if (openDrain) begin
        // Only the low side drives; ones float for the pull-up
        next_s.muxedPins.oeN = ~(s.regs.muxedPortDirReg & ~s.regs.muxedPortDataReg);
      end else begin
        next_s.muxedPins.oeN = ~s.regs.muxedPortDirReg;
      end
    end else if (s.busState == BUS_ADDR) begin
      next_s.muxedPins.out = s.busAddr[7:0];
      next_s.muxedPins.oeN = 8'h00;
    end else if (s.busState == BUS_DATA && s.busWrite) begin
      next_s.muxedPins.out = s.busWdata;
      next_s.muxedPins.oeN = 8'h00;
    end else begin
      next_s.muxedPins.out = s.busWdata;
      next_s.muxedPins.oeN = 8'hff;
    end

    // Fourth port: GPIO first, then peripheral and bus overrides
    next_s.serialPins.out = s.regs.serialPortDataReg;
    next_s.serialPins.oeN = ~s.regs.serialPortDirReg;
    if (sciEn) begin
      next_s.serialPins.oeN[0] = 1'b1;
      next_s.serialPins.out[1] = sciTxd;
      next_s.serialPins.oeN[1] = 1'b0;
    end
    if (spiEn) begin
      next_s.serialPins.out[5:2] = spiOut;
      next_s.serialPins.oeN[5:2] = ~spiDrive;
    end
    if (!gpioMode) begin
      next_s.serialPins.out[6] = (s.busState == BUS_ADDR);
      next_s.serialPins.out[7] = !(s.busState != BUS_IDLE && s.busWrite);
      next_s.serialPins.oeN[7:6] = 2'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign rdData       = s.rdData;
  assign rdValid      = s.rdValid;
  assign busRdData    = s.busRdData;
  assign busDone      = s.busDone;
  assign busBusy      = s.busBusy;
  assign expandedMode = s.expanded;
  assign timerPinOut  = s.timerPins.out;
  assign timerPinOeN  = s.timerPins.oeN;
  assign highPinOut   = s.highPins.out;
  assign highPinOeN   = s.highPins.oeN;
  assign muxedPinOut  = s.muxedPins.out;
  assign muxedPinOeN  = s.muxedPins.oeN;
  assign serialPinOut = s.serialPins.out;
  assign serialPinOeN = s.serialPins.oeN;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seqAddrPhase;
    serialPinOut[6] && muxedPinOeN == 8'h00;
  endsequence

  sequence seqDataPhase;
    !serialPinOut[6];
  endsequence

  a_bus_cycle_order: assert property (
    (busReq && s.expanded && s.busState == BUS_IDLE) |-> ##2 seqAddrPhase ##1 seqDataPhase
      ##[1:8] busDone)
    else $error("bus cycle did not run address then data phase");

  a_strobe_one_cycle: assert property (
    (expandedMode && $rose(serialPinOut[6])) |=> !serialPinOut[6])
    else $error("address strobe longer than one cycle");

  a_rw_write_low: assert property (
    (s.busState == BUS_DATA && s.busWrite) |=> (serialPinOut[7] == 1'b0))
    else $error("read/write not low during write");

  a_high_addr_out: assert property (
    (s.expanded && s.busState == BUS_ADDR) |=> (highPinOeN == 8'h00
      && highPinOut == $past(s.busAddr[15:8])))
    else $error("high address not driven in expanded mode");

  a_gpio_dir_follow: assert property (
    (!s.expanded && $stable(s.regs.highPortDirReg)) |=>
      (highPinOeN == ~$past(s.regs.highPortDirReg)))
    else $error("second port direction not following register");

  a_open_drain_float: assert property (
    (s.modeValid && s.mode == MODE_SINGLE && s.regs.parallelIoCtrlReg[PARALLEL_IO_CTRL_REG_OPEN_DRAIN])
      |=> ((~muxedPinOeN & $past(s.regs.muxedPortDataReg)) == 8'h00))
    else $error("open-drain port drove a one");

  a_timer_fixed_dir: assert property (
    (timerPinOeN[2:0] == 3'h7) && (timerPinOeN[6:4] == 3'h0))
    else $error("first port fixed directions wrong");

  a_compare_owns_pin: assert property (
    (compareEn[1] && regWr && regSel == REG_TIMER_PORT_DATA) |=>
      (timerPinOut[4] == $past(compareLevel[1])))
    else $error("write changed compare-owned pin");

  a_read_mixes_pin: assert property (
    (regRd && regSel == REG_HIGH_PORT_DATA) |=>
      (rdValid && rdData == ((~$past(highPinOeN) & $past(highPinOut))
        | ($past(highPinOeN) & $past(s.highSync)))))
    else $error("second port read value wrong");

endmodule : four_port_parallel_io_mux

// ### design/parallel_io_pkg.sv
// Shared constants and carriers for the four-port parallel I/O block
package parallel_io_pkg;

  // Register selector codes on the local register port
  localparam logic [3:0] REG_TIMER_PORT_DATA  = 4'h0;
  localparam logic [3:0] REG_PULSE_ACCUM_CTRL = 4'h1;
  localparam logic [3:0] REG_HIGH_PORT_DATA   = 4'h2;
  localparam logic [3:0] REG_HIGH_PORT_DIR    = 4'h3;
  localparam logic [3:0] REG_MUXED_PORT_DATA  = 4'h4;
  localparam logic [3:0] REG_MUXED_PORT_DIR   = 4'h5;
  localparam logic [3:0] REG_SERIAL_PORT_DATA = 4'h6;
  localparam logic [3:0] REG_SERIAL_PORT_DIR  = 4'h7;
  localparam logic [3:0] REG_PARALLEL_IO_CTRL = 4'h8;

  // Field positions
  localparam int PULSE_ACCUM_CTRL_REG_DIR_BIT7  = 7;
  localparam int PULSE_ACCUM_CTRL_REG_DIR_BIT3  = 3;
  localparam int PARALLEL_IO_CTRL_REG_OPEN_DRAIN = 5;

  // Values after reset
  localparam logic [7:0] RESET_DATA  = 8'h00;
  localparam logic [7:0] RESET_DIR   = 8'h00;
  localparam logic [7:0] RESET_PULSE_ACCUM_CTRL_REG = 8'h00;
  localparam logic [7:0] RESET_PARALLEL_IO_CTRL_REG  = 8'h00;

  // Mode strap codes {second strap, first strap}
  localparam logic [1:0] MODE_BOOT   = 2'h0;
  localparam logic [1:0] MODE_TEST   = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_EXP    = 2'h3;

  // Cycle counts
  localparam logic [1:0] STRAP_SETTLE    = 2'h2;
  localparam logic [2:0] BUS_DATA_CYCLES = 3'h4;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA} busState_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oeN;
  } portPins_t;

  typedef struct packed {
    logic [7:0] timerPortData;
    logic [7:0] pulseAccumCtrlReg;
    logic [7:0] highPortDataReg;
    logic [7:0] highPortDirReg;
    logic [7:0] muxedPortDataReg;
    logic [7:0] muxedPortDirReg;
    logic [7:0] serialPortDataReg;
    logic [7:0] serialPortDirReg;
    logic [7:0] parallelIoCtrlReg;
  } regFile_t;

  typedef struct packed {
    logic [1:0]  modeMeta;
    logic [1:0]  modeSync;
    logic [1:0]  modeCnt;
    logic        modeValid;
    logic [1:0]  mode;
    logic [7:0]  timerMeta;
    logic [7:0]  timerSync;
    logic [7:0]  highMeta;
    logic [7:0]  highSync;
    logic [7:0]  muxedMeta;
    logic [7:0]  muxedSync;
    logic [7:0]  serialMeta;
    logic [7:0]  serialSync;
    regFile_t    regs;
    busState_t   busState;
    logic [2:0]  busCnt;
    logic [15:0] busAddr;
    logic [7:0]  busWdata;
    logic        busWrite;
    logic [7:0]  busRdData;
    logic        busDone;
    logic        busBusy;
    logic        expanded;
    logic [7:0]  rdData;
    logic        rdValid;
    portPins_t   timerPins;
    portPins_t   highPins;
    portPins_t   muxedPins;
    portPins_t   serialPins;
  } ioState_t;

endpackage : parallel_io_pkg

// ### tb/bus_memory_model.sv
// External memory that sits on the multiplexed address/data bus
`timescale 1ns/1ns
module bus_memory_model
  import parallel_io_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Bus pins as seen outside
  input  wire logic [7:0] highOut,
  input  wire logic [7:0] muxedOut,
  input  wire logic [7:0] muxedOeN,
  input  wire logic [7:0] ctrlOut,
  input  wire logic [7:0] ctrlOeN,
  // Read data back onto the muxed lines
  output logic      [7:0] drive,
  output logic            driveEn
);
  logic [15:0] addr;
  logic        rw;
  logic [2:0]  cnt;
  logic [7:0]  mem [256];
  logic        strobe;

  assign strobe = ~ctrlOeN[6] & ctrlOut[6];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
    end else if (strobe) begin
      addr <= {highOut, muxedOut};
      rw   <= ctrlOut[7];
      cnt  <= BUS_DATA_CYCLES;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (!rw && muxedOeN == 8'h00) begin
        mem[addr[7:0]] <= muxedOut;
      end
    end
  end

  assign driveEn = rw & (cnt != 3'h0);
  // Released lines show the inverse so a stale sample cannot pass
  assign drive = driveEn ? mem[addr[7:0]] : ~mem[addr[7:0]];
endmodule : bus_memory_model

// ### tb/four_port_parallel_io_mux_test.sv
// Self-checking bench for the four-port parallel I/O block
`timescale 1ns/1ns
module four_port_parallel_io_mux_test;
  import parallel_io_pkg::*;
  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] wdata;
    logic [7:0] pins;
    logic [7:0] exp;
  } row_t;
  logic        sys_clk, rst, regWr, regRd, rdValid, sciEn, sciTxd, spiEn;
  logic        busReq, busWriteReq, busDone, busBusy, expandedMode, modelEn, expExp;
  logic [1:0]  modePins;
  logic [3:0]  regSel, spiOut, spiDrive;
  logic [4:0]  compareEn, compareLevel;
  logic [7:0]  regWdata, rdData, busWdataReq, busRdData, tbPins, modelDrive, got;
  logic [7:0]  timerPinOut, timerPinOeN, highPinOut, highPinOeN, muxedPinIn;
  logic [7:0]  muxedPinOut, muxedPinOeN, serialPinOut, serialPinOeN;
  logic [15:0] busAddrReq;
  int          miscompares, tests_run;
  row_t        rows [9] = '{
    '{REG_HIGH_PORT_DIR, 8'hff, 8'h00, 8'hff}, '{REG_HIGH_PORT_DATA, 8'ha5, 8'h00, 8'ha5},
    '{REG_MUXED_PORT_DIR, 8'h0f, 8'h00, 8'h0f}, '{REG_MUXED_PORT_DATA, 8'h96, 8'h3c, 8'h36},
    '{REG_SERIAL_PORT_DATA, 8'h5a, 8'hc3, 8'hc3}, '{REG_PULSE_ACCUM_CTRL, 8'h88, 8'h00, 8'h88},
    '{REG_TIMER_PORT_DATA, 8'hff, 8'h00, 8'hf8}, '{4'hf, 8'h77, 8'h00, 8'h00},
    '{REG_PARALLEL_IO_CTRL, 8'h20, 8'h00, 8'h20}};

  assign muxedPinIn = (muxedPinOut & ~muxedPinOeN)
                    | ((modelEn ? modelDrive : tbPins) & muxedPinOeN);

  four_port_parallel_io_mux dut (.sys_clk(sys_clk), .rst(rst), .modePins(modePins),
    .regWr(regWr), .regRd(regRd), .regSel(regSel), .regWdata(regWdata), .rdData(rdData),
    .rdValid(rdValid), .compareEn(compareEn), .compareLevel(compareLevel), .sciEn(sciEn),
    .sciTxd(sciTxd), .spiEn(spiEn), .spiOut(spiOut), .spiDrive(spiDrive), .busReq(busReq),
    .busWriteReq(busWriteReq), .busAddrReq(busAddrReq), .busWdataReq(busWdataReq),
    .busRdData(busRdData), .busDone(busDone), .busBusy(busBusy), .expandedMode(expandedMode),
    .timerPinIn(tbPins), .timerPinOut(timerPinOut), .timerPinOeN(timerPinOeN),
    .highPinIn(tbPins), .highPinOut(highPinOut), .highPinOeN(highPinOeN),
    .muxedPinIn(muxedPinIn), .muxedPinOut(muxedPinOut), .muxedPinOeN(muxedPinOeN),
    .serialPinIn(tbPins), .serialPinOut(serialPinOut), .serialPinOeN(serialPinOeN));

  bus_memory_model model (.sys_clk(sys_clk), .rst(rst), .highOut(highPinOut),
    .muxedOut(muxedPinOut), .muxedOeN(muxedPinOeN), .ctrlOut(serialPinOut),
    .ctrlOeN(serialPinOeN), .drive(modelDrive), .driveEn(modelEn));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp8

  task automatic regWrite(input logic [3:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regSel   <= s;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : regWrite

  task automatic regRead(input logic [3:0] s, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    regRd  <= 1'b1;
    regSel <= s;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    while (rdValid !== 1'b1 && n < 3) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    d = (rdValid === 1'b1) ? rdData : 8'hxx;
  endtask : regRead

  task automatic doReset(input logic [1:0] m);
    @(posedge sys_clk);
    rst      <= 1'b1;
    modePins <= m;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : doReset

  task automatic busCycle(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    busReq      <= 1'b1;
    busWriteReq <= wr;
    busAddrReq  <= a;
    busWdataReq <= d;
    @(posedge sys_clk);
    busReq <= 1'b0;
    #1;
    while (busDone !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp8({7'h00, busDone}, 8'h01);
    cmp8(model.addr[15:8], a[15:8]);
    cmp8(model.addr[7:0], a[7:0]);
    cmp8({7'h00, model.rw}, {7'h00, ~wr});
  endtask : busCycle

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    {rst, regWr, regRd, sciEn, sciTxd, spiEn, busReq, busWriteReq} = 8'h80;
    {modePins, regSel, spiOut, spiDrive, compareEn, compareLevel} = {MODE_SINGLE, 22'h0};
    {regWdata, busWdataReq, busAddrReq, tbPins} = 40'h0;
    miscompares = 0;
    tests_run = 0;
    doReset(MODE_SINGLE);
    cmp8(timerPinOeN, 8'h8f);
    cmp8(timerPinOut & 8'h70, 8'h00);
    cmp8(muxedPinOeN, 8'hff);
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      tbPins <= rows[i].pins;
      regWrite(rows[i].sel, rows[i].wdata);
      regRead(rows[i].sel, got);
      cmp8(got, rows[i].exp);
    end
    cmp8(highPinOut, 8'ha5);
    cmp8(highPinOeN, 8'h00);
    cmp8(timerPinOeN, 8'h07);
    cmp8(muxedPinOeN, 8'hf6);
    cmp8(muxedPinOut & 8'h09, 8'h00);
    regWrite(REG_PARALLEL_IO_CTRL, 8'h00);
    cmp8(muxedPinOeN, 8'hf0);
    cmp8(muxedPinOut & 8'h0f, 8'h06);
    @(posedge sys_clk);
    compareEn    <= 5'h02;
    compareLevel <= 5'h02;
    regWrite(REG_TIMER_PORT_DATA, 8'h00);
    cmp8(timerPinOut & 8'hf8, 8'h10);
    @(posedge sys_clk);
    {sciEn, sciTxd, spiEn, spiOut, spiDrive} <= {3'h7, 4'h1, 4'h5};
    regWrite(REG_SERIAL_PORT_DIR, 8'hc0);
    regWrite(REG_SERIAL_PORT_DATA, 8'h80);
    cmp8(serialPinOeN, 8'h29);
    cmp8(serialPinOut & 8'hd6, 8'h86);
    @(posedge sys_clk);
    busReq <= 1'b1;
    @(posedge sys_clk);
    busReq <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    cmp8({7'h00, busBusy}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      doReset(m[1:0]);
      expExp = (m[1:0] == MODE_TEST) || (m[1:0] == MODE_EXP);
      cmp8({7'h00, expandedMode}, {7'h00, expExp});
      cmp8(highPinOeN, expExp ? 8'h00 : 8'hff);
      cmp8(timerPinOeN, 8'h8f);
      // Bootstrap keeps push-pull drive even with the open-drain bit set
      if (m == 0) begin
        regWrite(REG_PARALLEL_IO_CTRL, 8'h20);
        regWrite(REG_MUXED_PORT_DIR, 8'h0f);
        regWrite(REG_MUXED_PORT_DATA, 8'h96);
        cmp8(muxedPinOeN, 8'hf0);
      end
    end
    regWrite(REG_HIGH_PORT_DIR, 8'hff);
    regWrite(REG_HIGH_PORT_DATA, 8'h3c);
    busCycle(1'b1, 16'h12a4, 8'h5e);
    busCycle(1'b0, 16'h12a4, 8'h00);
    cmp8(busRdData, 8'h5e);
    cmp8(highPinOeN, 8'h00);
    cmp8(highPinOut, 8'h12);
    wrap_up();
  end
endmodule : four_port_parallel_io_mux_test
